// File: verilog/sensor_end.sv
/*
 Sensor end of the single-wire link: power-up measurement, the power-up record (factory address only when FW_VERSION >= SUPPRESS_VERSION)
 power-up record, then command mode with address query and change address.
 Assumes the logger switches the supply through the link and that rst_n
 stands for a factory reset to address character zero, not for a supply cycle.
*/
// Operation
// RQ1 - Change address replies new address, adopts it
// RQ2 - Wildcard accepted except for change address
// RQ3 - Factory address is character zero
// RQ4 - Only alphanumeric characters become addresses
// RQ5 - Logger reassigns addresses only when alone
// RQ6 - Address query answers own address
// RQ7 - Logger queries only a lone sensor
// RQ8 - Record characters 1200 baud 8N1 non-inverted
// RQ9 - Line raised within 100 ms of power
// RQ10 - Power-up measures then sends record unprompted
// RQ11 - After record, command mode until repower
// RQ12 - Line low while measuring, then high idle
// RQ13 - Logger ignores line before first start
// RQ14 - Record framing order tab values CR type
// RQ15 - Checksum is sum mod 64 plus 32
// RQ16 - Checksum covers tab through type character
// RQ17 - Fixed type character follows first CR
// RQ18 - Non-zero address suppresses record, new firmware
// RQ19 - Record carries vapor pressure and temperature only
// RQ20 - Command characters 7E1 inverted at 1200
// RQ21 - Replies start with address, end CR LF
// RQ22 - Silent on commands for other addresses
// RQ23 - Address retained across supply cycles
module sensor_end #(
	parameter int BIT_CYCLES = link_pkg::BIT_CYCLES,
	parameter int MEASURE_CYCLES = link_pkg::MEASURE_CYCLES,
	parameter int SETTLE_CYCLES = link_pkg::SETTLE_CYCLES,
	parameter int FW_VERSION = link_pkg::SUPPRESS_VERSION,
	parameter logic [7:0] TYPE_CHAR = 8'h74 // Arbitrary model code
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Shared line and supply
	link_if.sensor link,
	// Measured values as ASCII, first character in the top byte
	input wire logic [link_pkg::TEXT_W-1:0] vapor_text,
	input wire logic [link_pkg::TEXT_W-1:0] temp_text,
	// Status
	output logic [7:0] address,
	output logic command_mode
);
	import link_pkg::*;

	typedef enum logic [2:0] {S_OFF, S_MEASURE, S_SETTLE, S_BURST, S_LISTEN, S_REPLY} sensor_state_e;

	typedef struct packed {
		sensor_state_e state;
		logic [TIMER_W-1:0] timer;
		logic [3:0] bit_idx;
		logic [3:0] char_idx;
		logic [CHECK_BITS-1:0] sum;
		logic [7:0] addr;
		logic [7:0] reply;
		logic [TEXT_W-1:0] vapor;
		logic [TEXT_W-1:0] temp;
		logic [7:0] hist1;
		logic [7:0] hist2;
		logic [7:0] hist3;
		logic [2:0] cmd_cnt;
		logic rx_busy;
		logic [7:0] rx_shift;
		logic line_f;
		logic drive;
		logic level;
	} sensor_s;

	localparam sensor_s SENSOR_RESET = '{state: S_OFF, addr: FACTORY_ADDRESS, default: '0};

	sensor_s st;
	sensor_s next_st;
	logic sync1;
	logic sync2;
	logic sync3;
	logic tick;
	logic [7:0] cur;
	logic [7:0] rx_char;
	logic [3:0] last_idx;

	// Address characters allowed
	function automatic logic is_alnum(input logic [7:0] c);
		return (c >= CHAR_D0 && c <= CHAR_D9) || (c >= CHAR_UA && c <= CHAR_UZ) ||
			(c >= CHAR_LA && c <= CHAR_LZ); // RQ4
	endfunction

	// Character being sent in the current state
	function automatic logic [7:0] tx_byte(input sensor_s s);
		logic [7:0] b;
		logic [1:0] k;
		b = s.reply; // RQ21
		k = 2'(s.char_idx - POS_VAPOR);
		if (s.state == S_BURST) begin
			// Tab, values, CR, type, checksum, CR LF
			case (s.char_idx) // RQ14
				POS_TAB: b = CHAR_TAB;
				POS_SPACE: b = CHAR_SPACE;
				POS_CR1, POS_CR2: b = CHAR_CR;
				POS_TYPE: b = TYPE_CHAR; // RQ17
				POS_CHECK: b = 8'(s.sum) + CHECK_OFFSET; // RQ15
				POS_LF: b = CHAR_LF;
				default: begin
					if (s.char_idx > POS_SPACE) begin
						k = 2'(s.char_idx - POS_TEMP);
						b = s.temp[8 * (VALUE_CHARS - 1 - int'(k)) +: 8];
					end else begin
						b = s.vapor[8 * (VALUE_CHARS - 1 - int'(k)) +: 8]; // RQ19
					end
				end
			endcase
		end else if (s.char_idx == REPLY_CR) begin
			b = CHAR_CR; // RQ21
		end else if (s.char_idx == REPLY_LF) begin
			b = CHAR_LF;
		end
		return b;
	endfunction

	// Pin level for a state: record frames plain, command frames inverted
	function automatic logic line_level(input sensor_s s);
		logic f;
		logic [7:0] b;
		b = tx_byte(s);
		if (s.bit_idx == BIT_START) begin
			f = 1'b0;
		end else if (s.bit_idx >= BIT_STOP) begin
			f = 1'b1;
		end else if (s.bit_idx == BIT_PARITY && s.state != S_BURST) begin
			f = ^b[6:0]; // RQ20
		end else begin
			f = b[3'(s.bit_idx - 4'h1)];
		end
		if (s.state == S_SETTLE) begin
			return 1'b1; // RQ12
		end
		if (s.state == S_BURST) begin
			return f; // RQ8
		end
		if (s.state == S_REPLY) begin
			return ~f; // RQ20
		end
		return 1'b0;
	endfunction

	// Line synchroniser
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= link.line;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Sequencer, transmitter, receiver and command decode
	always_comb begin
		next_st = st;
		tick = (st.timer == '0);
		cur = tx_byte(st);
		rx_char = {1'b0, st.rx_shift[6:0]};
		last_idx = (st.state == S_BURST) ? POS_LF : REPLY_LF;
		if (sync2 == sync3) begin
			next_st.line_f = sync3;
		end
		if (!tick) begin
			next_st.timer = st.timer - 1'b1;
		end
		unique case (st.state)
			S_OFF: begin
				if (link.power) begin
					next_st.state = S_MEASURE; // RQ10
					next_st.timer = TIMER_W'(MEASURE_CYCLES - 1);
					next_st.drive = 1'b1; // RQ12
				end
			end
			S_MEASURE: begin
				if (tick) begin
					next_st.vapor = vapor_text;
					next_st.temp = temp_text;
					if (FW_VERSION >= SUPPRESS_VERSION && st.addr != FACTORY_ADDRESS) begin
						next_st.state = S_LISTEN; // RQ18
						next_st.drive = 1'b0;
					end else begin
						next_st.state = S_SETTLE; // RQ9
						next_st.timer = TIMER_W'(SETTLE_CYCLES - 1);
					end
				end
			end
			S_SETTLE: begin
				if (tick) begin
					next_st.state = S_BURST; // RQ12
					next_st.timer = TIMER_W'(BIT_CYCLES - 1);
					next_st.bit_idx = BIT_START;
					next_st.char_idx = POS_TAB;
					next_st.sum = '0;
				end
			end
			S_BURST, S_REPLY: begin
				if (tick) begin
					next_st.timer = TIMER_W'(BIT_CYCLES - 1); // RQ8
					if (st.bit_idx == BIT_GAP) begin
						// Drive only once the logger has released its stop bit
						next_st.bit_idx = BIT_START;
						next_st.drive = 1'b1; // RQ21
					end else if (st.bit_idx < BIT_STOP) begin
						next_st.bit_idx = st.bit_idx + 4'h1;
					end else begin
						if (st.char_idx <= POS_TYPE) begin
							next_st.sum = st.sum + cur[CHECK_BITS-1:0]; // RQ16
						end
						next_st.bit_idx = BIT_START;
						if (st.char_idx == last_idx) begin
							next_st.state = S_LISTEN; // RQ11
							next_st.drive = 1'b0;
							next_st.rx_busy = 1'b0;
						end else begin
							next_st.char_idx = st.char_idx + 4'h1;
						end
					end
				end
			end
			S_LISTEN: begin
				if (!st.rx_busy) begin
					if (st.line_f) begin
						next_st.rx_busy = 1'b1; // RQ20
						next_st.timer = TIMER_W'(BIT_CYCLES / 2 - 1);
						next_st.bit_idx = BIT_START;
					end
				end else if (tick) begin
					next_st.timer = TIMER_W'(BIT_CYCLES - 1);
					next_st.bit_idx = st.bit_idx + 4'h1;
					if (st.bit_idx == BIT_START) begin
						next_st.rx_busy = st.line_f;
					end else if (st.bit_idx < BIT_STOP) begin
						next_st.rx_shift = {~st.line_f, st.rx_shift[7:1]};
					end else begin
						next_st.rx_busy = 1'b0;
						if (st.line_f || ^st.rx_shift) begin
							next_st.cmd_cnt = '0; // RQ20
						end else if (rx_char == CHAR_BANG) begin
							next_st.cmd_cnt = '0;
							if (st.cmd_cnt == CMD_QUERY && st.hist1 == CHAR_WILD) begin
								next_st.reply = st.addr; // RQ6 RQ2
								next_st.state = S_REPLY;
							end else if (st.cmd_cnt == CMD_CHANGE && st.hist3 == st.addr &&
								st.hist2 == CHAR_CHANGE && is_alnum(st.hist1)) begin
								next_st.addr = st.hist1; // RQ1 RQ2 RQ4 RQ23
								next_st.reply = st.hist1;
								next_st.state = S_REPLY;
							end
						end else begin
							next_st.hist3 = st.hist2; // RQ22
							next_st.hist2 = st.hist1;
							next_st.hist1 = rx_char;
							if (st.cmd_cnt != CMD_FULL) begin
								next_st.cmd_cnt = st.cmd_cnt + 3'h1;
							end
						end
						if (next_st.state == S_REPLY) begin
							next_st.drive = 1'b0; // Gap bit left to the pull-down
							next_st.char_idx = '0;
							next_st.bit_idx = BIT_GAP;
						end
					end
				end
			end
		endcase
		// Supply loss stops everything but keeps the address
		if (!link.power) begin
			next_st.state = S_OFF; // RQ11 RQ23
			next_st.drive = 1'b0;
			next_st.rx_busy = 1'b0;
			next_st.cmd_cnt = '0;
		end
		next_st.level = line_level(next_st);
	end

	// State register; the address survives supply cycles
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st <= SENSOR_RESET; // RQ3
		end else begin
			st <= next_st;
		end
	end

	// Pin and status outputs
	assign link.sensor_oe = st.drive;
	assign link.sensor_out = st.level;
	assign address = st.addr;
	assign command_mode = (st.state == S_LISTEN) || (st.state == S_REPLY);
endmodule

// File: verilog/link_pkg.sv
/*
 Shared constants for the single-wire sensor link: bit timing, power-up
 timing, frame bit positions, record layout and character codes.
 Assumes a single 125 MHz clock on both ends.
*/
package link_pkg;
	// Clock and line rates
	localparam int CLOCK_HZ = 125_000_000;
	localparam int BAUD_RATE = 1200;
	localparam int BIT_CYCLES = CLOCK_HZ / BAUD_RATE;
	// Longest time from power to the raised line, and the hold phases inside it
	localparam int POWER_UP_MS = 100;
	localparam int POWER_UP_CYCLES = CLOCK_HZ / 1000 * POWER_UP_MS;
	localparam int MEASURE_CYCLES = POWER_UP_CYCLES / 2;
	localparam int SETTLE_MS = 20;
	localparam int SETTLE_CYCLES = CLOCK_HZ / 1000 * SETTLE_MS;
	localparam int TIMER_W = 24;
	// Frame bit positions, shared by both character formats
	localparam logic [3:0] BIT_START = 4'h0;
	localparam logic [3:0] BIT_PARITY = 4'h8;
	localparam logic [3:0] BIT_STOP = 4'h9;
	localparam logic [3:0] BIT_GAP = 4'hA;
	// Power-up record layout
	localparam int VALUE_CHARS = 4;
	localparam int TEXT_W = 8 * VALUE_CHARS;
	localparam logic [3:0] POS_TAB = 4'h0;
	localparam logic [3:0] POS_VAPOR = 4'h1;
	localparam logic [3:0] POS_SPACE = 4'h5;
	localparam logic [3:0] POS_TEMP = 4'h6;
	localparam logic [3:0] POS_CR1 = 4'hA;
	localparam logic [3:0] POS_TYPE = 4'hB;
	localparam logic [3:0] POS_CHECK = 4'hC;
	localparam logic [3:0] POS_CR2 = 4'hD;
	localparam logic [3:0] POS_LF = 4'hE;
	// Command reply layout
	localparam logic [3:0] REPLY_CR = 4'h1;
	localparam logic [3:0] REPLY_LF = 4'h2;
	// Characters seen before the closing mark
	localparam logic [2:0] CMD_QUERY = 3'h1;
	localparam logic [2:0] CMD_CHANGE = 3'h3;
	localparam logic [2:0] CMD_FULL = 3'h4;
	// Checksum
	localparam int CHECK_BITS = 6;
	localparam logic [7:0] CHECK_OFFSET = 8'h20;
	// Address state and firmware threshold
	localparam logic [7:0] FACTORY_ADDRESS = 8'h30;
	localparam int SUPPRESS_VERSION = 350;
	// Character codes
	localparam logic [7:0] CHAR_TAB = 8'h09;
	localparam logic [7:0] CHAR_LF = 8'h0A;
	localparam logic [7:0] CHAR_CR = 8'h0D;
	localparam logic [7:0] CHAR_SPACE = 8'h20;
	localparam logic [7:0] CHAR_BANG = 8'h21;
	localparam logic [7:0] CHAR_WILD = 8'h3F;
	localparam logic [7:0] CHAR_CHANGE = 8'h41;
	localparam logic [7:0] CHAR_D0 = 8'h30;
	localparam logic [7:0] CHAR_D9 = 8'h39;
	localparam logic [7:0] CHAR_UA = 8'h41;
	localparam logic [7:0] CHAR_UZ = 8'h5A;
	localparam logic [7:0] CHAR_LA = 8'h61;
	localparam logic [7:0] CHAR_LZ = 8'h7A;
endpackage

// File: verilog/link_if.sv
/*
 The shared data line and the sensor supply between logger and sensor.
 Assumes a weak pull-down: an undriven line reads low.
*/
interface link_if;
	logic power;
	logic sensor_out;
	logic sensor_oe;
	logic logger_out;
	logic logger_oe;
	logic line;

	// Resolved wire level from the two enables
	assign line = sensor_oe ? sensor_out : (logger_oe ? logger_out : 1'b0);

	modport sensor (input power, input line, output sensor_out, output sensor_oe);
	modport logger (input line, output power, output logger_out, output logger_oe);
endinterface

// File: verilog/pair_buffer.sv
/*
 Small FIFO with valid and ready on both sides.
 Assumes DEPTH is a power of two so the pointers wrap by themselves.
*/
module pair_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	// Handshakes and head entry
	assign in_ready = (count != (AW + 1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	// Pointer and fill level update
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = wr_ptr + AW'(push);
		next_rd_ptr = rd_ptr + AW'(pop);
		next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	// Storage and pointers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

// File: verilog/logger_end.sv
/*
 Logger end of the single-wire link: switches the sensor supply, decodes
 the power-up record and checks its checksum, then sends queued command
 characters and decodes replies in command mode.
 Assumes only one end drives the line at a time.
*/
module logger_end #(
	parameter int BIT_CYCLES = link_pkg::BIT_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Shared line and supply
	link_if.logger link,
	// Supply control
	input wire logic power_request,
	input wire logic expect_burst,
	// Command characters to send
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	// Received characters
	output logic rx_valid,
	output logic [7:0] rx_data,
	// Record status
	output logic burst_mode,
	output logic burst_good,
	output logic burst_bad
);
	import link_pkg::*;

	typedef enum logic [1:0] {P_BODY, P_TYPE, P_CHECK, P_TAIL} phase_e;

	typedef struct packed {
		logic power;
		logic burst_mode;
		logic armed;
		phase_e phase;
		logic [TIMER_W-1:0] timer;
		logic [3:0] bit_idx;
		logic rx_busy;
		logic [7:0] rx_shift;
		logic tx_busy;
		logic [7:0] tx_data;
		logic drive;
		logic level;
		logic line_f;
		logic [CHECK_BITS-1:0] sum;
		logic rx_valid;
		logic [7:0] rx_data;
		logic good;
		logic bad;
	} logger_s;

	localparam logger_s LOGGER_RESET = '{phase: P_BODY, default: '0};

	logger_s st;
	logger_s next_st;
	logic sync1;
	logic sync2;
	logic sync3;
	logic tick;
	logic act;
	logic f;
	logic [7:0] c;
	logic buf_valid;
	logic buf_take;
	logic [7:0] buf_data;

	// Command queue; a busy line stalls the user
	pair_buffer #(.WIDTH(8), .DEPTH(2)) cmd_queue (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(cmd_valid),
		.in_data(cmd_data),
		.in_ready(cmd_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(buf_take)
	);

	// Line synchroniser
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= link.line;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Queue drains only when the line is free in command mode
	assign buf_take = buf_valid && st.power && !st.tx_busy && !st.rx_busy && !st.burst_mode;

	// Supply, transmitter, receiver and record check
	always_comb begin
		next_st = st;
		next_st.rx_valid = 1'b0;
		tick = (st.timer == '0);
		act = st.burst_mode ? ~st.line_f : st.line_f;
		c = st.burst_mode ? st.rx_shift : {1'b0, st.rx_shift[6:0]};
		if (sync2 == sync3) begin
			next_st.line_f = sync3;
		end
		if (!tick) begin
			next_st.timer = st.timer - 1'b1;
		end
		next_st.power = power_request;
		if (buf_take) begin
			next_st.tx_busy = 1'b1; // RQ20
			next_st.tx_data = buf_data;
			next_st.bit_idx = BIT_START;
			next_st.timer = TIMER_W'(BIT_CYCLES - 1);
			next_st.drive = 1'b1;
		end else if (st.tx_busy) begin
			if (tick) begin
				next_st.timer = TIMER_W'(BIT_CYCLES - 1);
				next_st.bit_idx = st.bit_idx + 4'h1;
				if (st.bit_idx == BIT_STOP) begin
					next_st.tx_busy = 1'b0;
					next_st.drive = 1'b0;
				end
			end
		end else if (!st.armed) begin
			next_st.armed = st.line_f; // RQ13
		end else if (!st.rx_busy) begin
			if (act) begin
				next_st.rx_busy = 1'b1; // RQ13
				next_st.timer = TIMER_W'(BIT_CYCLES / 2 - 1);
				next_st.bit_idx = BIT_START;
			end
		end else if (tick) begin
			next_st.timer = TIMER_W'(BIT_CYCLES - 1);
			next_st.bit_idx = st.bit_idx + 4'h1;
			if (st.bit_idx == BIT_START) begin
				next_st.rx_busy = act;
			end else if (st.bit_idx < BIT_STOP) begin
				next_st.rx_shift = {~act, st.rx_shift[7:1]};
			end else begin
				next_st.rx_busy = 1'b0;
				if (!act && (st.burst_mode || !(^st.rx_shift))) begin
					next_st.rx_valid = 1'b1; // RQ8 RQ20
					next_st.rx_data = c;
					if (st.burst_mode) begin
						unique case (st.phase)
							P_BODY: begin
								next_st.sum = st.sum + c[CHECK_BITS-1:0]; // RQ16
								if (c == CHAR_CR) begin
									next_st.phase = P_TYPE;
								end
							end
							P_TYPE: begin
								next_st.sum = st.sum + c[CHECK_BITS-1:0]; // RQ16
								next_st.phase = P_CHECK;
							end
							P_CHECK: begin
								next_st.good = (c == 8'(st.sum) + CHECK_OFFSET); // RQ15
								next_st.bad = (c != 8'(st.sum) + CHECK_OFFSET);
								next_st.phase = P_TAIL;
							end
							P_TAIL: begin
								if (c == CHAR_LF) begin
									next_st.burst_mode = 1'b0; // RQ11
								end
							end
						endcase
					end
				end
			end
		end
		// Fresh supply cycle restarts record decoding
		if (power_request && !st.power) begin
			next_st.burst_mode = expect_burst; // RQ10
			next_st.armed = !expect_burst;
			next_st.phase = P_BODY;
			next_st.sum = '0;
			next_st.good = 1'b0;
			next_st.bad = 1'b0;
			next_st.rx_busy = 1'b0;
		end
		// Outgoing command frame, inverted on the pin
		if (next_st.bit_idx == BIT_START) begin
			f = 1'b0;
		end else if (next_st.bit_idx >= BIT_STOP) begin
			f = 1'b1;
		end else if (next_st.bit_idx == BIT_PARITY) begin
			f = ^next_st.tx_data[6:0];
		end else begin
			f = next_st.tx_data[3'(next_st.bit_idx - 4'h1)];
		end
		next_st.level = ~f; // RQ20
	end

	// State register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st <= LOGGER_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Pin and user outputs
	assign link.power = st.power;
	assign link.logger_oe = st.drive;
	assign link.logger_out = st.level;
	assign rx_valid = st.rx_valid;
	assign rx_data = st.rx_data;
	assign burst_mode = st.burst_mode;
	assign burst_good = st.good;
	assign burst_bad = st.bad;
endmodule

// File: testbench/link_assertions.sv
/*
 Checker on the link wire: power-up timing, record start, command framing.
 Assumes it sits beside the link interface, watching its signals.
*/
module link_assertions #(
	parameter int BIT_CYCLES = 16,
	parameter int MEASURE_CYCLES = 40,
	parameter int SETTLE_CYCLES = 20
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Link signals
	input wire logic power,
	input wire logic sensor_out,
	input wire logic sensor_oe,
	input wire logic logger_out,
	input wire logic logger_oe,
	input wire logic line
);
	import link_pkg::*;
	localparam int MID_LOW = MEASURE_CYCLES / 2;
	localparam int MID_HIGH = MEASURE_CYCLES + SETTLE_CYCLES / 2;
	localparam int MID_START = MEASURE_CYCLES + SETTLE_CYCLES + BIT_CYCLES / 2;
	localparam int MID_BIT0 = MID_START + BIT_CYCLES;
	localparam int CHAR_CYCLES = 10 * BIT_CYCLES;
	logic [15:0] on_count;
	logic [15:0] next_on_count;
	logic [15:0] oe_run;
	logic [15:0] next_oe_run;

	// Cycles since power came on, length of the logger's drive
	always_comb begin
		next_on_count = 16'h0000;
		if (power)
			next_on_count = on_count + {15'h0000, on_count != 16'hFFFF};
		next_oe_run = logger_oe ? oe_run + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			on_count <= 16'h0000;
			oe_run <= 16'h0000;
		end else begin
			on_count <= next_on_count;
			oe_run <= next_oe_run;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_power_off; !power |=> !sensor_oe; endproperty
	a_power_off: assert property (p_power_off) else $error("sensor drives unpowered");
	property p_measure_low; sensor_oe && on_count == MID_LOW |-> !sensor_out; endproperty
	a_measure_low: assert property (p_measure_low) else $error("line not low");
	property p_raised; sensor_oe && on_count == MID_HIGH |-> sensor_out; endproperty
	a_raised: assert property (p_raised) else $error("line not raised");
	property p_first_start; sensor_oe && on_count == MID_START |-> !sensor_out; endproperty
	a_first_start: assert property (p_first_start) else $error("no start bit");
	property p_tab_lsb; sensor_oe && on_count == MID_BIT0 |-> sensor_out; endproperty
	a_tab_lsb: assert property (p_tab_lsb) else $error("tab bit 0 wrong");
	property p_one_driver; !(sensor_oe && logger_oe); endproperty
	a_one_driver: assert property (p_one_driver) else $error("both ends drive");
	property p_idle_low; !sensor_oe && !logger_oe |-> !line; endproperty
	a_idle_low: assert property (p_idle_low) else $error("undriven line not low");
	property p_logger_start; $rose(logger_oe) |-> logger_out; endproperty
	a_logger_start: assert property (p_logger_start) else $error("start not high");
	property p_logger_length; $fell(logger_oe) |-> (int'(oe_run) % CHAR_CYCLES) == 0; endproperty
	a_logger_length: assert property (p_logger_length) else $error("char length");
	property p_logger_stop; $past(rst_n) && $fell(logger_oe) |-> !$past(logger_out); endproperty
	a_logger_stop: assert property (p_logger_stop) else $error("stop not low");
endmodule

// File: testbench/tb.sv
/*
 Testbench joining sensor and logger ends through the link interface.
 Assumes shortened bit counts on both ends, and shortened measure and settle counts on the sensor.
*/
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import link_pkg::*;
	localparam int BIT = 16;
	localparam int MEAS = 40;
	localparam int SETTLE = 20;
	localparam int LIMIT = 400 * BIT;
	localparam logic [7:0] TYPE = 8'h74; // Arbitrary model code
	logic clock, rst_n, power_request, expect_burst, cmd_valid, cmd_ready;
	logic rx_valid, burst_mode, burst_good, burst_bad, command_mode;
	logic [7:0] cmd_data, rx_data, address;
	logic [31:0] vapor_text, temp_text;
	int mismatches;
	int cmp_count;
	link_if link_bus ();

	// Both ends and the wire checker
	sensor_end #(.BIT_CYCLES(BIT), .MEASURE_CYCLES(MEAS), .SETTLE_CYCLES(SETTLE),
		.TYPE_CHAR(TYPE)) sensor_end_inst (.clock(clock), .rst_n(rst_n),
		.link(link_bus.sensor), .vapor_text(vapor_text), .temp_text(temp_text),
		.address(address), .command_mode(command_mode));
	logger_end #(.BIT_CYCLES(BIT)) logger_end_inst (.clock(clock), .rst_n(rst_n),
		.link(link_bus.logger), .power_request(power_request), .expect_burst(expect_burst),
		.cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .burst_mode(burst_mode),
		.burst_good(burst_good), .burst_bad(burst_bad));
	link_assertions #(.BIT_CYCLES(BIT), .MEASURE_CYCLES(MEAS), .SETTLE_CYCLES(SETTLE))
		link_assertions_inst (.clock(clock), .rst_n(rst_n), .power(link_bus.power),
		.sensor_out(link_bus.sensor_out), .sensor_oe(link_bus.sensor_oe),
		.logger_out(link_bus.logger_out), .logger_oe(link_bus.logger_oe),
		.line(link_bus.line));

	// Clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task check(string what, logic [7:0] seen, logic [7:0] expected);
		cmp_count++;
		if (seen !== expected) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, expected, seen);
		end
	endtask

	task test_done();
		$display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Next received character, bounded wait
	task get_char(logic [7:0] expected);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (rx_valid !== 1'b1 && n < LIMIT);
		if (n >= LIMIT) begin
			mismatches++;
			test_done();
		end
		check("rx char", rx_data, expected);
	endtask

	// Whole reply, then let the sensor finish its stop bit
	task reply(string s);
		for (int i = 0; i < s.len(); i++) get_char(s[i]);
		repeat (2 * BIT) @(posedge clock);
		#1;
	endtask

	// Queue command characters; a full queue holds us back
	task send(string s);
		int n;
		for (int i = 0; i < s.len(); i++) begin
			cmd_valid = 1'b1;
			cmd_data = s[i];
			n = 0;
			while (cmd_ready !== 1'b1 && n < LIMIT) begin
				@(posedge clock);
				#1;
				n++;
			end
			if (n >= LIMIT) begin
				mismatches++;
				test_done();
			end
			@(posedge clock);
			#1;
		end
		cmd_valid = 1'b0;
	endtask

	// No character may arrive for a while
	task silent(string what);
		int seen;
		seen = 0;
		repeat (60 * BIT) begin
			@(posedge clock);
			#1;
			if (rx_valid === 1'b1) seen++;
		end
		check(what, seen[7:0], 8'h00);
	endtask

	// Power cycle and read the record
	task t_burst();
		logic [7:0] rec [15];
		int sum;
		rec = '{CHAR_TAB, "1", ".", "1", "7", CHAR_SPACE, "2", "2", ".", "3",
			CHAR_CR, TYPE, 8'h00, CHAR_CR, CHAR_LF};
		sum = 0;
		for (int i = 0; i < 12; i++) sum += rec[i];
		rec[12] = 8'((sum % 64) + 32);
		power_request = 1'b0;
		repeat (4) @(posedge clock);
		#1;
		expect_burst = 1'b1;
		power_request = 1'b1;
		repeat (MEAS / 2) @(posedge clock);
		#1;
		check("line measuring", {7'h00, link_bus.line}, 8'h00);
		repeat (MEAS / 2 + SETTLE / 2) @(posedge clock);
		#1;
		check("line raised", {7'h00, link_bus.line}, 8'h01);
		for (int i = 0; i < 15; i++) get_char(rec[i]);
		check("burst good", {7'h00, burst_good}, 8'h01);
		check("burst bad", {7'h00, burst_bad}, 8'h00);
		check("burst mode", {7'h00, burst_mode}, 8'h00);
		repeat (2 * BIT) @(posedge clock);
		#1;
		check("command mode", {7'h00, command_mode}, 8'h01);
		$display("burst test done");
	endtask

	// Query, refusals, then a chain of address changes
	task t_address();
		string chain, s, r;
		chain = "0bZ7";
		send("?!");
		reply("0\r\n");
		send("5A7!");
		silent("other address");
		send("?A7!");
		silent("wildcard change");
		send("0A#!");
		silent("bad new address");
		check("idle line", {7'h00, link_bus.line}, 8'h00);
		check("address kept", address, 8'h30);
		s = "xAx!";
		r = "x\r\n";
		for (int i = 0; i < 3; i++) begin
			s[0] = chain[i];
			s[2] = chain[i + 1];
			r[0] = chain[i + 1];
			send(s);
			reply(r);
			check("new address", address, chain[i + 1]);
		end
		send("ZA1!");
		silent("old address");
		send("?!");
		reply("7\r\n");
		$display("address test done");
	endtask

	// Repower with a non-zero address: no record
	task t_repower();
		expect_burst = 1'b0;
		power_request = 1'b0;
		repeat (4) @(posedge clock);
		#1;
		power_request = 1'b1;
		silent("no record");
		check("address retained", address, "7");
		check("command mode", {7'h00, command_mode}, 8'h01);
		check("no burst mode", {7'h00, burst_mode}, 8'h00);
		send("?!");
		reply("7\r\n");
		$display("repower test done");
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		power_request = 1'b0;
		expect_burst = 1'b0;
		cmd_valid = 1'b0;
		cmd_data = 8'h00;
		vapor_text = "1.17";
		temp_text = "22.3";
		mismatches = 0;
		cmp_count = 0;
		repeat (4) @(posedge clock);
		#1;
		rst_n = 1'b1;
		check("factory address", address, 8'h30);
		check("cmd ready", {7'h00, cmd_ready}, 8'h01);
		t_burst();
		t_burst();
		t_address();
		t_repower();
		test_done();
	end
endmodule
